// ==== include/fbes_pkg.sv ====
// Constants and types for the flash block erase sequencer.
// Assumes a single 250 MHz core clock.
package fbes_pkg;
    // Clock period in picoseconds
    localparam int unsigned CLK_PERIOD_PS      = 4000;
    // Largest group erase size and its bit index
    localparam int unsigned GROUP_MAX          = 128;
    localparam int unsigned GROUP_MAX_LOG2     = 7;
    // Block number width
    localparam int unsigned BLOCK_W            = 16;
    // Step counter width
    localparam int unsigned STEP_W             = 16;
    // Least gap after a baud rate set exchange, in ns
    localparam int unsigned BAUD_GAP_NS        = 66000;
    localparam int unsigned BAUD_GAP_CYC       = (BAUD_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Least block erase processing time, in us
    localparam int unsigned ERASE_MIN_US       = 17500;
    localparam int unsigned ERASE_MIN_CYC      = (ERASE_MIN_US * 1000) / (CLK_PERIOD_PS / 1000) / 1000 * 1000;
    // Count width for all waits
    localparam int unsigned WAIT_W             = 32;

    typedef enum logic [4:0] {
        FBES_IDLE   = 5'h01,
        FBES_PICK   = 5'h02,
        FBES_ERASE  = 5'h04,
        FBES_HOLD   = 5'h08,
        FBES_STATUS = 5'h10
    } fbes_state_t;
endpackage

// ==== rtl/fbes_gap_timer.sv ====
// Down counter that holds busy for a loaded number of cycles.
// Assumes a single clock and asynchronous active-low reset.
`timescale 1ns/1ps
module fbes_gap_timer #(
    parameter int unsigned WIDTH = 32
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadCount,
    output logic                  busy
);
    // Elaboration check on counter width
    if (WIDTH < 1) begin
        $error("Counter width must be at least one bit");
    end

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    // =======================================
    // Count
    always_comb begin
        count_next = count_reg;
        if (load) begin
            count_next = loadCount;
        end else if (count_reg != '0) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign busy = (count_reg != '0);
endmodule

// ==== rtl/fbes_sequencer.sv ====
// Flash block erase sequencer: splits a range into aligned groups.
// Assumes command inputs synchronous to core_clk; the flash array
// answers each group erase with a one-cycle done pulse.
// Function
// - Finish command no earlier than minimum time, then send status
// - Accept next command after baud gap
// - Range erase runs as group steps
// - Group sizes are powers of two
// - Group size not above remaining count
// - Start block divisible by group size
// - Largest size passing both tests wins
// - Search from 128, halving each time
// - Advance start, reduce remaining per step
// - Count group steps of the range
`timescale 1ns/1ps
module fbes_sequencer
    import fbes_pkg::*;
#(
    parameter int unsigned ERASE_MIN_CYCLES = ERASE_MIN_CYC,
    parameter int unsigned BAUD_GAP_CYCLES  = BAUD_GAP_CYC
) (
    input  wire logic                         core_clk,
    input  wire logic                         reset_n,
    input  wire logic                         eraseStart,
    input  wire logic [fbes_pkg::BLOCK_W-1:0] firstBlock,
    input  wire logic [fbes_pkg::BLOCK_W-1:0] blockCount,
    input  wire logic                         baudSetDone,
    input  wire logic                         groupEraseDone,
    output logic                              groupEraseReq,
    output logic [fbes_pkg::BLOCK_W-1:0]      groupStartBlock,
    output logic [fbes_pkg::GROUP_MAX_LOG2:0] groupBlockCount,
    output logic [fbes_pkg::STEP_W-1:0]       stepCount,
    output logic                              statusValid,
    output logic                              busy,
    output logic                              commReady
);
    import fbes_pkg::*;

    // =======================================
    // Elaboration checks
    if (ERASE_MIN_CYCLES < 1 || BAUD_GAP_CYCLES < 1) begin
        $error("Wait counts must be at least one cycle");
    end
    if (GROUP_MAX != (32'h1 << GROUP_MAX_LOG2)) begin
        $error("Largest group must be two to its index");
    end
    if (GROUP_MAX_LOG2 >= BLOCK_W) begin
        $error("Block width too narrow for largest group");
    end
    if (WAIT_W < 2) begin
        $error("Wait counter too narrow");
    end

    fbes_state_t                 state_reg, state_next;
    logic [BLOCK_W-1:0]          start_reg, start_next;
    logic [BLOCK_W-1:0]          remain_reg, remain_next;
    logic [GROUP_MAX_LOG2:0]     group_reg, group_next;
    logic [STEP_W-1:0]           steps_reg, steps_next;
    logic                        req_reg, req_next;
    logic                        status_reg, status_next;
    logic                        busy_reg, busy_next;
    logic                        ready_reg, ready_next;
    logic                        minBusy;
    logic                        gapBusy;
    logic                        minLoad;

    // =======================================
    // Group size choice
    function automatic logic [GROUP_MAX_LOG2:0] pick_group(
        input logic [BLOCK_W-1:0] start,
        input logic [BLOCK_W-1:0] remain
    );
        logic [GROUP_MAX_LOG2:0] size;
        logic [BLOCK_W-1:0]      mask;
        logic                    found;
        size  = '0;
        found = 1'b0;
        for (int i = GROUP_MAX_LOG2; i >= 0; i--) begin
            mask = BLOCK_W'((1 << i) - 1);
            if (!found && (remain >= BLOCK_W'(1 << i)) && ((start & mask) == '0)) begin
                size  = (GROUP_MAX_LOG2 + 1)'(1 << i);
                found = 1'b1;
            end
        end
        return size;
    endfunction

    // =======================================
    // Command acceptance
    function automatic logic gap_clear(
        input logic timerBusy,
        input logic baudPulse
    );
        return !timerBusy && !baudPulse;
    endfunction

    // =======================================
    // Timers
    // minimum processing time
    fbes_gap_timer #(.WIDTH(WAIT_W)) u_min_timer (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .load      (minLoad),
        .loadCount (WAIT_W'(ERASE_MIN_CYCLES)),
        .busy      (minBusy)
    );

    fbes_gap_timer #(.WIDTH(WAIT_W)) u_gap_timer (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .load      (baudSetDone),
        .loadCount (WAIT_W'(BAUD_GAP_CYCLES)),
        .busy      (gapBusy)
    );

    assign minLoad = (state_reg == FBES_IDLE) && eraseStart && ready_reg;

    // =======================================
    // Sequencer
    always_comb begin
        state_next  = state_reg;
        start_next  = start_reg;
        remain_next = remain_reg;
        group_next  = group_reg;
        steps_next  = steps_reg;
        req_next    = 1'b0;
        status_next = 1'b0;
        busy_next   = busy_reg;
        ready_next  = (state_reg == FBES_IDLE) && gap_clear(gapBusy, baudSetDone);
        unique case (state_reg)
            FBES_IDLE: begin
                if (eraseStart && ready_reg) begin
                    start_next  = firstBlock;
                    remain_next = blockCount;
                    steps_next  = '0;
                    busy_next   = 1'b1;
                    ready_next  = 1'b0;
                    state_next  = (blockCount == '0) ? FBES_HOLD : FBES_PICK;
                end
            end
            FBES_PICK: begin
                group_next = pick_group(start_reg, remain_reg);
                req_next   = 1'b1;
                state_next = FBES_ERASE;
                ready_next = 1'b0;
            end
            FBES_ERASE: begin
                ready_next = 1'b0;
                if (groupEraseDone) begin
                    start_next  = start_reg + BLOCK_W'(group_reg);
                    remain_next = remain_reg - BLOCK_W'(group_reg);
                    steps_next  = steps_reg + 1'b1;
                    state_next  = (remain_reg == BLOCK_W'(group_reg)) ? FBES_HOLD : FBES_PICK;
                end
            end
            FBES_HOLD: begin
                ready_next = 1'b0;
                if (!minBusy) begin
                    status_next = 1'b1;
                    state_next  = FBES_STATUS;
                end
            end
            FBES_STATUS: begin
                busy_next  = 1'b0;
                state_next = FBES_IDLE;
                ready_next = gap_clear(gapBusy, baudSetDone);
            end
            default: begin
                state_next = FBES_IDLE;
                busy_next  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg  <= FBES_IDLE;
            start_reg  <= '0;
            remain_reg <= '0;
            group_reg  <= '0;
            steps_reg  <= '0;
            req_reg    <= 1'b0;
            status_reg <= 1'b0;
            busy_reg   <= 1'b0;
            ready_reg  <= 1'b0;
        end else begin
            state_reg  <= state_next;
            start_reg  <= start_next;
            remain_reg <= remain_next;
            group_reg  <= group_next;
            steps_reg  <= steps_next;
            req_reg    <= req_next;
            status_reg <= status_next;
            busy_reg   <= busy_next;
            ready_reg  <= ready_next;
        end
    end

    // =======================================
    // Outputs
    assign groupEraseReq   = req_reg;
    assign groupStartBlock = start_reg;
    assign groupBlockCount = group_reg;
    assign stepCount       = steps_reg;
    assign statusValid     = status_reg;
    assign busy            = busy_reg;
    assign commReady       = ready_reg;
endmodule

// ==== verification/fbes_flash_model.sv ====
// Flash array model: answers each group erase with a done pulse.
// Assumes one core clock; slow stretches the erase time.
`timescale 1ns/1ps
module fbes_flash_model (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic groupEraseReq,
    input  wire logic slow,
    output logic      groupEraseDone
);
    int wait_reg;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_reg       <= 0;
            groupEraseDone <= 1'b0;
        end else begin
            groupEraseDone <= (wait_reg == 1);
            if (groupEraseReq) wait_reg <= slow ? 12 : 1;
            else if (wait_reg > 0) wait_reg <= wait_reg - 1;
        end
    end
endmodule

// ==== verification/fbes_seq_sva.sv ====
// Checker on the sequencer ports.
// Assumes a bind onto fbes_sequencer.
`timescale 1ns/1ps
module fbes_seq_chk
    import fbes_pkg::*;
#(
    parameter int unsigned ERASE_MIN_CYCLES = 50,
    parameter int unsigned BAUD_GAP_CYCLES  = 20
) (
    input wire logic                core_clk,
    input wire logic                reset_n,
    input wire logic                eraseStart,
    input wire logic                baudSetDone,
    input wire logic                groupEraseReq,
    input wire logic [BLOCK_W-1:0]  groupStartBlock,
    input wire logic [GROUP_MAX_LOG2:0] groupBlockCount,
    input wire logic                statusValid,
    input wire logic                busy,
    input wire logic                commReady
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    int unsigned age;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) age <= 0;
        else age <= busy ? age + 1 : 0;
    end
    sequence take_s; eraseStart && commReady; endsequence
    sequence finish_s; statusValid ##1 !statusValid; endsequence
    group_pow2_a: assert property (groupEraseReq |-> $onehot(groupBlockCount)) else $error("size");
    group_align_a: assert property (groupEraseReq |->
        (groupStartBlock & ({8'h00, groupBlockCount} - 16'h0001)) == 16'h0000) else $error("align");
    req_pulse_a: assert property (groupEraseReq |=> !groupEraseReq) else $error("req pulse");
    req_busy_a: assert property (groupEraseReq |-> busy) else $error("req idle");
    take_busy_a: assert property (take_s |=> busy && !commReady) else $error("take");
    refuse_start_a: assert property (eraseStart && !commReady && !busy |=> !busy) else $error("refuse");
    baud_gap_a: assert property (baudSetDone |-> ##1 !commReady [*8]) else $error("gap");
    min_time_a: assert property (statusValid |-> age >= ERASE_MIN_CYCLES) else $error("min");
    status_end_a: assert property (finish_s |-> ##[0:1] !busy) else $error("end");
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the erase sequencer.
// Assumes the flash model and checker files.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; $display("MISMATCH %0t differs", $time); end end
module testbench;
    import fbes_pkg::*;
    localparam int unsigned MIN_C = 50;
    localparam int unsigned GAP_C = 20;
    logic                    core_clk = 1'b0;
    logic                    reset_n = 1'b0;
    logic                    eraseStart = 1'b0;
    logic                    baudSetDone = 1'b0;
    logic                    slow = 1'b0;
    logic [BLOCK_W-1:0]      firstBlock = 16'h0000;
    logic [BLOCK_W-1:0]      blockCount = 16'h0000;
    logic [BLOCK_W-1:0]      groupStartBlock;
    logic [GROUP_MAX_LOG2:0] groupBlockCount;
    logic [STEP_W-1:0]       stepCount;
    logic                    groupEraseDone, groupEraseReq, statusValid, busy, commReady;
    int                      fail_count = 0;
    int                      checks_done = 0;
    int                      cycles = 0;
    always #2 core_clk = ~core_clk;
    fbes_sequencer #(.ERASE_MIN_CYCLES(MIN_C), .BAUD_GAP_CYCLES(GAP_C)) u_fbes_sequencer (
        .core_clk(core_clk), .reset_n(reset_n), .eraseStart(eraseStart), .firstBlock(firstBlock),
        .blockCount(blockCount), .baudSetDone(baudSetDone), .groupEraseDone(groupEraseDone),
        .groupEraseReq(groupEraseReq), .groupStartBlock(groupStartBlock), .groupBlockCount(groupBlockCount),
        .stepCount(stepCount), .statusValid(statusValid), .busy(busy), .commReady(commReady));
    fbes_flash_model u_fbes_flash_model (.core_clk(core_clk), .reset_n(reset_n),
        .groupEraseReq(groupEraseReq), .slow(slow), .groupEraseDone(groupEraseDone));
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic run_range(input logic [15:0] f, input logic [15:0] n, input logic [15:0] m);
        logic [15:0] s, r, g;
        int t;
        s = f; r = n; t = 0;
        while (commReady !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        eraseStart <= 1'b1; firstBlock <= f; blockCount <= n;
        @(posedge core_clk);
        eraseStart <= 1'b0;
        while (statusValid !== 1'b1 && t < 4000) begin
            @(negedge core_clk);
            t++;
            if (groupEraseReq === 1'b1) begin
                g = 16'h0080;
                while (g > 16'h0001 && (g > r || (s & (g - 16'h0001)) != 16'h0000)) g = g >> 1;
                `CHK(groupStartBlock, s)
                `CHK({8'h00, groupBlockCount}, g)
                s = s + g; r = r - g;
            end
        end
        `CHK(statusValid, 1'b1)
        `CHK(r, 16'h0000)
        `CHK(stepCount, m)
        `CHK(t > MIN_C, 1'b1)
    endtask
    task automatic test_examples();
        run_range(16'h0001, 16'h007F, 16'h0007);
        run_range(16'h0005, 16'h0006, 16'h0004);
        run_range(16'h0010, 16'h0000, 16'h0000);
    endtask
    task automatic test_slow_flash();
        slow <= 1'b1;
        run_range(16'h0019, 16'h0031, 16'h0006);
        slow <= 1'b0;
    endtask
    task automatic test_max_group();
        run_range(16'h0000, 16'h0100, 16'h0002);
    endtask
    task automatic test_baud_gap();
        int n;
        n = 0;
        @(posedge core_clk);
        baudSetDone <= 1'b1;
        @(posedge core_clk);
        baudSetDone <= 1'b0;
        eraseStart <= 1'b1; firstBlock <= 16'h0004; blockCount <= 16'h0004;
        @(posedge core_clk);
        eraseStart <= 1'b0;
        while (commReady !== 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(busy, 1'b0)
        `CHK(n >= GAP_C, 1'b1)
        run_range(16'h0004, 16'h0004, 16'h0001);
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        test_examples();
        test_slow_flash();
        test_max_group();
        test_baud_gap();
        end_sim();
    end
endmodule
bind fbes_sequencer fbes_seq_chk #(.ERASE_MIN_CYCLES(ERASE_MIN_CYCLES), .BAUD_GAP_CYCLES(BAUD_GAP_CYCLES)) u_chk (
    .core_clk(core_clk), .reset_n(reset_n), .eraseStart(eraseStart), .baudSetDone(baudSetDone),
    .groupEraseReq(groupEraseReq), .groupStartBlock(groupStartBlock), .groupBlockCount(groupBlockCount),
    .statusValid(statusValid), .busy(busy), .commReady(commReady));
